// ---- inc/mailbox_map.vh ----
// Notes on behaviour
// - write permit drops on write, returns later
// - read permit drops on read, returns later
// - channel object up to 7f wide, 3f narrow
// - chip object up to 3 wide, 1 narrow
// - object ignored for objectless commands
// - opcode first, then every expected operand
// - s-tag reprograms setup and clears data
// - codes 05-09 manage stored configurations
// - codes 10-13 take one 12-bit operand
// - 14/15 subtraction on/off, 16 reads five
// - 22 sets edge detection, 23 reads it
// - 24 edge resolution, 25 pair, 26 reads
// - 28 sets dead time, 29 reads it
// - 30/31 frame words on/off, 32 reads
// - 33 sets event size, reprograms setup
// - boot image chosen by jumper at power-on
// - mode query lsb 1 window matching
// - mode select adjusts reject, subtract, token
`ifndef MAILBOX_MAP_VH
`define MAILBOX_MAP_VH
// register byte offsets
`define MB_OFS_MAILBOX   8'h00
`define MB_OFS_HANDSHAKE 8'h04
`define MB_OFS_STATUS    8'h08
`define MB_OFS_CTRL      8'h0c
// handshake bit positions
`define MB_HS_WRITE_BIT  0
`define MB_HS_READ_BIT   1
// ctrl bit positions and reset
`define MB_CTRL_NARROW_BIT 0
`define MB_CTRL_RESET      1'b0
// object limits per variant
`define MB_CHAN_MAX_WIDE   8'h7f
`define MB_CHAN_MAX_NARROW 8'h3f
`define MB_CHIP_MAX_WIDE   8'h03
`define MB_CHIP_MAX_NARROW 8'h01
// factory configuration
`define MB_DEF_WIDTH   12'h014
`define MB_DEF_OFFSET  12'hfd8
`define MB_DEF_SEARCH  12'h008
`define MB_DEF_REJECT  12'h004
`define MB_DEF_EVSIZE  16'h0009
// microcontroller turnaround per word
`define MB_CLK_NS      40
`define MB_ACCEPT_NS   200
`define MB_ACCEPT_CYC  ((`MB_ACCEPT_NS + `MB_CLK_NS - 1) / `MB_CLK_NS)
`endif

// ---- src/opcode_mailbox.v ----
`timescale 1ns/100ps
`include "mailbox_map.vh"
module opcode_mailbox #(
  parameter ADDR_W = 8                    // apb address width
) (
  input  wire              pclk,          // bus clock, 25 MHz
  input  wire              presetn,       // async reset, active low
  input  wire              psel,          // apb select
  input  wire              penable,       // apb access phase
  input  wire              pwrite,        // apb direction
  input  wire [ADDR_W-1:0] paddr,         // apb byte address
  input  wire [31:0]       pwdata,        // apb write data
  output reg  [31:0]       prdata,        // apb read data
  output reg               pready,        // apb ready
  output reg               pslverr,       // apb error
  input  wire              image_jumper,  // jumper pin, 1 selects backup image
  output reg               boot_image,    // 0 primary_image, 1 backup_image
  output reg               boot_valid,    // jumper captured
  output reg               setup_reprog,  // pulse: setup registers rewritten
  output reg               data_clear,    // pulse: acquired data cleared
  output reg               ctrl_reprog,   // pulse: control registers rewritten
  output reg               window_match   // 1 window matching, 0 free running
);
  // one-hot states of the exchange sequencer
  localparam [3:0] ST_OPCODE = 4'b0001;   // waiting for an opcode word
  localparam [3:0] ST_OPND   = 4'b0010;   // waiting for a written operand
  localparam [3:0] ST_BUSY   = 4'b0100;   // microcontroller turnaround
  localparam [3:0] ST_READ   = 4'b1000;   // response word offered
  localparam [31:0] ACC_FULL = `MB_ACCEPT_CYC;  // turnaround in whole cycles
  localparam [7:0] ACC_CYC   = ACC_FULL[7:0];   // counter width, cut on purpose

  reg  [3:0]  state;           // sequencer state
  reg  [7:0]  busy_cnt;        // turnaround countdown
  reg  [15:0] word;            // last word taken from the host
  reg         word_is_op;      // last word was an opcode
  reg  [7:0]  cmd;             // command of the open exchange
  reg  [2:0]  rd_left;         // read operands still owed
  reg  [2:0]  rd_idx;          // index of next response word
  reg  [15:0] resp;            // response word on offer
  reg         write_permit_flag;
  reg         read_permit_flag;
  reg         bad_object;      // last opcode had an illegal object
  reg         unknown_cmd;     // last opcode was not recognised
  reg         narrow;          // ctrl: narrow variant limits
  reg         acc_ok;          // mailbox access legal at wait cycle
  reg  [2:0]  jmp_sync;        // jumper synchroniser
  reg  [1:0]  warm;            // synchroniser fill count
  // configuration held for the converters
  reg         keep_token, reject_auto, subtract_on, frame_words;
  reg         autoload_user;
  reg  [11:0] win_width, win_offset, search_m, reject_m;
  reg  [1:0]  detection, edge_res, dead_time;
  reg  [15:0] pair_res, event_size;
  reg  [90:0] user_cfg;        // saved user configuration

  // command in the upper byte, object in the lower byte
  wire [7:0]  op_cmd   = word[15:8];
  wire [7:0]  op_obj   = word[7:0];
  wire [7:0]  exec_cmd = word_is_op ? op_cmd : cmd;
  wire        apb_wait = psel & penable & ~pready;
  wire        apb_done = psel & penable & pready;
  wire        at_mbox  = (paddr == `MB_OFS_MAILBOX);
  wire        wr_evt   = apb_done & pwrite & at_mbox & acc_ok;
  wire        rd_evt   = apb_done & ~pwrite & at_mbox & acc_ok;
  wire        busy_done = (state == ST_BUSY) && (busy_cnt == 8'h00);
  wire [90:0] cfg_now  = {window_match, keep_token, reject_auto, subtract_on,
                          frame_words, win_width, win_offset, search_m, reject_m,
                          detection, edge_res, dead_time, pair_res, event_size};

  // written operand count per command
  function [2:0] n_wr;
    input [7:0] c;
    begin
      case (c)
        8'h10, 8'h11, 8'h12, 8'h13: n_wr = 3'h1;
        8'h22, 8'h24, 8'h25, 8'h28: n_wr = 3'h1;
        8'h33:                      n_wr = 3'h1;
        default:                    n_wr = 3'h0;
      endcase
    end
  endfunction

  // read operand count per command
  function [2:0] n_rd;
    input [7:0] c;
    begin
      case (c)
        8'h02, 8'h23, 8'h26, 8'h29, 8'h32: n_rd = 3'h1;
        8'h16:                             n_rd = 3'h5;
        default:                           n_rd = 3'h0;
      endcase
    end
  endfunction

  // commands this sequencer recognises
  function known;
    input [7:0] c;
    begin
      case (c)
        8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
        8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h22, 8'h23, 8'h24,
        8'h25, 8'h26, 8'h28, 8'h29, 8'h30, 8'h31, 8'h32, 8'h33,
        8'h40, 8'h41, 8'h42, 8'h43: known = 1'b1;
        default:                    known = 1'b0;
      endcase
    end
  endfunction

  // setup-register tag: reprogram with data clear
  function tag_setup;
    input [7:0] c;
    begin
      case (c)
        8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h07, 8'h10, 8'h11, 8'h12, 8'h13,
        8'h14, 8'h15, 8'h22, 8'h24, 8'h25, 8'h28, 8'h30, 8'h31,
        8'h33:   tag_setup = 1'b1;
        default: tag_setup = 1'b0;
      endcase
    end
  endfunction

  // object check; objectless commands pass whatever object they carry
  function obj_ok;
    input [7:0] c;
    input [7:0] o;
    input       nar;
    begin
      case (c)
        8'h40, 8'h41, 8'h52, 8'h53:
          obj_ok = (o <= (nar ? `MB_CHAN_MAX_NARROW : `MB_CHAN_MAX_WIDE));
        8'h60, 8'h74, 8'h75, 8'h76:
          obj_ok = (o <= (nar ? `MB_CHIP_MAX_NARROW : `MB_CHIP_MAX_WIDE));
        default: obj_ok = 1'b1;
      endcase
    end
  endfunction

  // response word for a read command at operand index
  function [15:0] respond;
    input [7:0] c;
    input [2:0] i;
    begin
      case (c)
        8'h02: respond = {15'h0000, window_match};
        8'h16: case (i)
                 3'h0:    respond = {4'h0, win_width};
                 3'h1:    respond = {4'h0, win_offset};
                 3'h2:    respond = {4'h0, search_m};
                 3'h3:    respond = {4'h0, reject_m};
                 default: respond = {15'h0000, subtract_on};
               endcase
        8'h23: respond = {14'h0000, detection};
        8'h26: respond = (detection == 2'b11) ? pair_res :
                         {14'h0000, edge_res};
        8'h29: respond = {14'h0000, dead_time};
        8'h32: respond = {15'h0000, frame_words};
        default: respond = 16'h0000;
      endcase
    end
  endfunction

  // an exchange completes when its last written word has been absorbed
  wire op_good = obj_ok(op_cmd, op_obj, narrow);
  wire fire    = busy_done & ((word_is_op & op_good & (n_wr(op_cmd) == 3'h0) &
                 (n_rd(op_cmd) == 3'h0)) | (~word_is_op & (rd_left == 3'h0)));

  // apb slave: one wait state, access legality latched in the wait cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      acc_ok  <= 1'b0;
      narrow  <= `MB_CTRL_RESET;
    end else if (apb_wait) begin
      pready  <= 1'b1;
      acc_ok  <= pwrite ? write_permit_flag : read_permit_flag;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      case (paddr)
        `MB_OFS_MAILBOX: begin
          prdata  <= {16'h0000, resp};       // stale unless read permit set
          pslverr <= pwrite & ~write_permit_flag;
        end
        `MB_OFS_HANDSHAKE: begin
          prdata[`MB_HS_WRITE_BIT] <= write_permit_flag;
          prdata[`MB_HS_READ_BIT]  <= read_permit_flag;
        end
        `MB_OFS_STATUS: begin
          prdata[11:0] <= {boot_valid, boot_image, unknown_cmd, bad_object,
                           autoload_user, frame_words, subtract_on, reject_auto,
                           keep_token, window_match, (state != ST_OPCODE), 1'b0};
        end
        `MB_OFS_CTRL: prdata[`MB_CTRL_NARROW_BIT] <= narrow;
        default:      pslverr <= 1'b1;     // unmapped address
      endcase
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      // ctrl write lands at the completing edge only
      if (apb_done && pwrite && paddr == `MB_OFS_CTRL)
        narrow <= pwdata[`MB_CTRL_NARROW_BIT];
    end
  end

  // exchange sequencer and handshake flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state             <= ST_OPCODE;
      busy_cnt          <= 8'h00;
      word              <= 16'h0000;
      word_is_op        <= 1'b0;
      cmd               <= 8'h00;
      rd_left           <= 3'h0;
      rd_idx            <= 3'h0;
      resp              <= 16'h0000;
      write_permit_flag <= 1'b1;
      read_permit_flag  <= 1'b0;
      bad_object        <= 1'b0;
      unknown_cmd       <= 1'b0;
    end else begin
      case (state)
        ST_OPCODE, ST_OPND: begin
          if (wr_evt) begin
            write_permit_flag <= 1'b0;
            word              <= pwdata[15:0];
            word_is_op        <= (state == ST_OPCODE);
            busy_cnt          <= ACC_CYC - 8'h01;
            state             <= ST_BUSY;
          end
        end
        ST_READ: begin
          if (rd_evt) begin
            read_permit_flag <= 1'b0;
            word_is_op       <= 1'b0;
            busy_cnt         <= ACC_CYC - 8'h01;
            state            <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (busy_cnt != 8'h00) begin
            busy_cnt <= busy_cnt - 8'h01;
          end else if (word_is_op) begin
            cmd         <= op_cmd;
            bad_object  <= ~op_good;
            unknown_cmd <= ~known(op_cmd);
            rd_left     <= n_rd(op_cmd);
            rd_idx      <= 3'h1;
            if (op_good && n_wr(op_cmd) != 3'h0) begin
              write_permit_flag <= 1'b1;
              state             <= ST_OPND;
            end else if (op_good && n_rd(op_cmd) != 3'h0) begin
              resp             <= respond(op_cmd, 3'h0);
              read_permit_flag <= 1'b1;
              state            <= ST_READ;
            end else begin
              write_permit_flag <= 1'b1;
              state             <= ST_OPCODE;
            end
          end else if (rd_left > 3'h1) begin
            // more response words owed before the exchange ends
            rd_left          <= rd_left - 3'h1;
            rd_idx           <= rd_idx + 3'h1;
            resp             <= respond(cmd, rd_idx);
            read_permit_flag <= 1'b1;
            state            <= ST_READ;
          end else begin
            rd_left           <= 3'h0;
            write_permit_flag <= 1'b1;
            state             <= ST_OPCODE;
          end
        end
        default: state <= ST_OPCODE;
      endcase
    end
  end

  // reprogramming strobes; control tag covers the channel-enable group
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_reprog <= 1'b0;
      data_clear   <= 1'b0;
      ctrl_reprog  <= 1'b0;
    end else begin
      setup_reprog <= fire & tag_setup(exec_cmd);
      data_clear   <= fire & tag_setup(exec_cmd);
      ctrl_reprog  <= fire & (exec_cmd[7:2] == 6'b010000);
    end
  end

  // converter configuration, applied when an exchange completes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      window_match  <= 1'b0;
      keep_token    <= 1'b0;
      reject_auto   <= 1'b0;
      subtract_on   <= 1'b0;
      frame_words   <= 1'b0;
      autoload_user <= 1'b0;
      win_width     <= `MB_DEF_WIDTH;
      win_offset    <= `MB_DEF_OFFSET;
      search_m      <= `MB_DEF_SEARCH;
      reject_m      <= `MB_DEF_REJECT;
      detection     <= 2'b00;
      edge_res      <= 2'b00;
      dead_time     <= 2'b00;
      pair_res      <= 16'h0000;
      event_size    <= `MB_DEF_EVSIZE;
      user_cfg      <= 91'h0;
    end else if (fire) begin
      case (exec_cmd)
        8'h00: begin
          window_match <= 1'b1;
          reject_auto  <= 1'b1;
          keep_token   <= 1'b1;
        end
        8'h01: begin
          window_match <= 1'b0;
          reject_auto  <= 1'b0;
          subtract_on  <= 1'b0;
        end
        8'h03: keep_token <= 1'b1;
        8'h04: keep_token <= 1'b0;
        8'h05: begin
          window_match <= 1'b0;
          win_width    <= `MB_DEF_WIDTH;
          win_offset   <= `MB_DEF_OFFSET;
          search_m     <= `MB_DEF_SEARCH;
          reject_m     <= `MB_DEF_REJECT;
        end
        8'h06: user_cfg <= cfg_now;
        8'h07: {window_match, keep_token, reject_auto, subtract_on, frame_words,
                win_width, win_offset, search_m, reject_m, detection, edge_res,
                dead_time, pair_res, event_size} <= user_cfg;
        8'h08: autoload_user <= 1'b1;
        8'h09: autoload_user <= 1'b0;
        8'h10: win_width  <= word[11:0];
        8'h11: win_offset <= word[11:0];
        8'h12: search_m   <= word[11:0];
        8'h13: reject_m   <= word[11:0];
        8'h14: subtract_on <= 1'b1;
        8'h15: subtract_on <= 1'b0;
        8'h22: detection  <= word[1:0];
        8'h24: edge_res   <= word[1:0];
        8'h25: pair_res   <= word;
        8'h28: dead_time  <= word[1:0];
        8'h30: frame_words <= 1'b1;
        8'h31: frame_words <= 1'b0;
        8'h33: event_size <= word;
        default: ;                                                // nothing stored
      endcase
    end
  end

  // jumper: three-stage sync, captured once stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jmp_sync   <= 3'b000;
      warm       <= 2'b00;
      boot_image <= 1'b0;
      boot_valid <= 1'b0;
    end else begin
      jmp_sync <= {jmp_sync[1:0], image_jumper};
      if (warm != 2'b11)
        warm <= warm + 2'b01;                 // wait until stages hold samples
      else if (!boot_valid && (jmp_sync[1] == jmp_sync[2])) begin
        boot_image <= jmp_sync[2];
        boot_valid <= 1'b1;
      end
    end
  end
endmodule

// ---- tb/opcode_mailbox_asserts.sv ----
`timescale 1ns/100ps
`include "mailbox_map.vh"
// watches handshake timing and reprogramming pulses at the block pins
module opcode_mailbox_asserts #(parameter ADDR_W = 8) (
  input wire              pclk,
  input wire              presetn,
  input wire              psel,
  input wire              penable,
  input wire              pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0]       pwdata,
  input wire [31:0]       prdata,
  input wire              pready,
  input wire              pslverr,
  input wire              image_jumper,
  input wire              boot_image,
  input wire              boot_valid,
  input wire              setup_reprog,
  input wire              data_clear,
  input wire              ctrl_reprog,
  input wire              window_match
);
  // completed transfers of interest
  wire done  = psel && penable && pready;
  wire mb_wr = done && pwrite && paddr == `MB_OFS_MAILBOX;
  wire wr_ok = mb_wr && !pslverr;
  wire hs_rd = done && !pwrite && paddr == `MB_OFS_HANDSHAKE;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_one_wait: assert property ((psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_bad_addr: assert property (done && paddr > `MB_OFS_CTRL |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_permit_busy: assert property (wr_ok |=> (!mb_wr || pslverr) [*4])
    else $error("mailbox word taken while permit low");
  a_permit_low: assert property (wr_ok |=> (!hs_rd || !prdata[`MB_HS_WRITE_BIT]) [*4])
    else $error("write permit still high after word");
  a_clear_pair: assert property ((setup_reprog || data_clear) |-> setup_reprog && data_clear)
    else $error("data clear not paired with setup reprogram");
  a_ctrl_keep: assert property (ctrl_reprog |-> !data_clear)
    else $error("control reprogram cleared data");
  a_boot_pick: assert property ($rose(boot_valid) |-> boot_image == $past(image_jumper))
    else $error("boot image differs from jumper");
  a_boot_soon: assert property ($rose(presetn) |-> ##[0:8] boot_valid)
    else $error("boot image not captured in time");
endmodule
bind opcode_mailbox opcode_mailbox_asserts #(.ADDR_W(ADDR_W)) u_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .image_jumper, .boot_image,
  .boot_valid, .setup_reprog, .data_clear, .ctrl_reprog, .window_match);

// ---- tb/apb_host.sv ----
`timescale 1ns/100ps
// bus host: moves mailbox words only while the matching permit reads 1
module apb_host (
  input  wire         pclk,
  input  wire  [31:0] prdata,
  input  wire         pready,
  input  wire         pslverr,
  output logic        psel = 1'b0,
  output logic        penable = 1'b0,
  output logic        pwrite = 1'b0,
  output logic [7:0]  paddr = 8'h00,
  output logic [31:0] pwdata = 32'h0,
  output logic        hung = 1'b0
);
  // one transfer; an idle edge first so psel never takes two values at once
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
    int n;
    begin
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (pready !== 1'b1 && n < 64);
      if (n >= 64) hung = 1'b1;
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // poll a handshake bit, bounded so a dead permit ends the run
  task permit(input int b);
    logic [31:0] r;
    logic        e;
    int          n;
    begin
      n = 0;
      do begin
        xfer(1'b0, 8'h04, 32'h0, r, e);
        n++;
      end while (r[b] !== 1'b1 && n < 40);
      if (n >= 40) hung = 1'b1;
    end
  endtask
  // mailbox words only; this host never rewrites a stored image
  task mb_write(input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    begin
      permit(0);
      xfer(1'b1, 8'h00, d, r, e);
    end
  endtask
  task mb_read(output logic [31:0] v);
    logic e;
    begin
      permit(1);
      xfer(1'b0, 8'h00, 32'h0, v, e);
    end
  endtask
endmodule

// ---- tb/opcode_mailbox_handshake_bench.sv ----
`timescale 1ns/100ps
`include "mailbox_map.vh"
module opcode_mailbox_handshake_bench;
  logic        pclk, presetn, image_jumper, psel, penable, pwrite, hung;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        pready, pslverr, boot_image, boot_valid;
  logic        setup_reprog, data_clear, ctrl_reprog, window_match;
  int          errors, checks_done, n_setup, n_clear, n_ctrl, cyc;
  opcode_mailbox uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .image_jumper, .boot_image, .boot_valid, .setup_reprog, .data_clear,
    .ctrl_reprog, .window_match);
  apb_host host (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata,
    .hung);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // pulse tallies; a hung host or runaway run closes out as a failure
  always @(posedge pclk) begin
    cyc++;
    if (setup_reprog === 1'b1) n_setup++;
    if (data_clear === 1'b1) n_clear++;
    if (ctrl_reprog === 1'b1) n_ctrl++;
    if (hung === 1'b1 || cyc > 50000) begin
      errors++;
      final_report;
    end
  end
  task final_report;
    if (errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task cmd(input logic [15:0] w);
    host.mb_write({16'h0000, w});
  endtask
  task rd;
    host.mb_read(r);
  endtask
  task rr(input logic [7:0] a);
    logic e;
    host.xfer(1'b0, a, 32'h0, r, e);
  endtask
  task wctl(input logic v);
    logic e;
    host.xfer(1'b1, `MB_OFS_CTRL, {31'h0, v}, r, e);
  endtask
  // the sequencer needs five cycles per word; eight leaves margin
  task settle;
    repeat (8) @(posedge pclk);
  endtask
  task t_reset;
    logic e;
    begin
      rr(`MB_OFS_HANDSHAKE);
      chk(r, 32'h1);
      host.xfer(1'b0, 8'h10, 32'h0, r, e);
      chk({r[30:0], e}, 32'h1);
      rr(`MB_OFS_STATUS);
      chk(r[11:10], 2'b11);
    end
  endtask
  task t_mode;
    int s0, c0;
    begin
      s0 = n_setup;
      c0 = n_clear;
      cmd(16'h005a);
      settle;
      chk(window_match, 1'b1);
      chk(n_setup - s0, 1);
      chk(n_clear - c0, 1);
      rr(`MB_OFS_STATUS);
      chk(r[4:3], 2'b11);
      cmd(16'h0200);
      rd;
      chk(r[0], 1'b1);
      rr(`MB_OFS_HANDSHAKE);
      chk(r[1], 1'b0);
      cmd(16'h0100);
      settle;
      chk(window_match, 1'b0);
      rr(`MB_OFS_STATUS);
      chk(r[5:4], 2'b00);
      cmd(16'h0200);
      rd;
      chk(r[0], 1'b0);
    end
  endtask
  // read back the five trigger words: width, offset, search, reject, subtract
  task tq(input logic [59:0] exp);
    int i;
    begin
      cmd(16'h1600);
      for (i = 0; i < 5; i++) begin
        rd;
        chk(r, {20'h0, exp[59-12*i -: 12]});
      end
    end
  endtask
  task t_trigger;
    logic [47:0] v;
    int          i;
    begin
      v = 48'h123_456_0ab_0cd;
      for (i = 0; i < 4; i++) begin
        cmd({4'h1, i[3:0], 8'h00});
        cmd({4'h0, v[47-12*i -: 12]});
      end
      cmd(16'h1400);
      tq({v, 12'h001});
      cmd(16'h0600);
      cmd(16'h0500);
      tq({`MB_DEF_WIDTH, `MB_DEF_OFFSET, `MB_DEF_SEARCH, `MB_DEF_REJECT, 12'h001});
      cmd(16'h0700);
      tq({v, 12'h001});
      cmd(16'h1500);
      tq({v, 12'h000});
      cmd(16'h0800);
      settle;
      rr(`MB_OFS_STATUS);
      chk(r[7], 1'b1);
      cmd(16'h0900);
      settle;
      rr(`MB_OFS_STATUS);
      chk(r[7], 1'b0);
    end
  endtask
  // rows: set code, operand, query code, expected answer
  task t_edge;
    logic [63:0] t [7];
    int          i, s0;
    begin
      t = '{64'h2200_0002_2300_0002, 64'h2400_0001_2600_0001, 64'h2200_0003_2300_0003,
            64'h2500_a5c3_2600_a5c3, 64'h2800_0003_2900_0003, 64'h3000_0000_3200_0001,
            64'h3100_0000_3200_0000};
      s0 = n_setup;
      for (i = 0; i < 7; i++) begin
        cmd(t[i][63:48]);
        if (t[i][63:56] < 8'h30) cmd(t[i][47:32]);
        cmd(t[i][31:16]);
        rd;
        chk(r, {16'h0, t[i][15:0]});
      end
      settle;
      chk(n_setup - s0, 7);
    end
  endtask
  // refused chip selector flags bad_object and opens no read; a legal one clears it
  task chip(input logic [15:0] bad, input logic [15:0] good);
    cmd(bad);
    repeat (10) @(posedge pclk);
    rr(`MB_OFS_HANDSHAKE);
    chk(r[1], 1'b0);
    rr(`MB_OFS_STATUS);
    chk(r[8], 1'b1);
    cmd(good);
    settle;
    rr(`MB_OFS_STATUS);
    chk(r[8], 1'b0);
  endtask
  task t_objects;
    int c0, k0;
    begin
      c0 = n_ctrl;
      k0 = n_clear;
      cmd(16'h407f);
      cmd(16'h4080);
      cmd(16'h4200);
      wctl(1'b1);
      cmd(16'h4040);
      cmd(16'h43ff);
      cmd(16'h413f);
      chip(16'h6002, 16'h6001);
      wctl(1'b0);
      chip(16'h6004, 16'h6003);
      settle;
      chk(n_ctrl - c0, 4);
      chk(n_clear - k0, 0);
    end
  endtask
  // keep-token clear, event size with its operand, then an unrecognised code
  task t_misc;
    int s0;
    begin
      s0 = n_setup;
      cmd(16'h0400);
      cmd(16'h3300);
      cmd(16'h0040);
      cmd(16'hc600);
      settle;
      rr(`MB_OFS_STATUS);
      chk(r[9:8], 2'b10);
      chk(r[3], 1'b0);
      chk(n_setup - s0, 2);
    end
  endtask
  initial begin
    presetn      = 1'b0;
    image_jumper = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_mode;
    t_trigger;
    t_edge;
    t_objects;
    t_misc;
    final_report;
  end
endmodule
